// *** hw/ogp_gpio.sv ***
/*
 Two 4-bit GPIO ports behind an AXI4-Lite slave: an oscillator-shared
 port and an interrupt-shared port, with pin drivers and pull-ups.
 Assumes pins are synchronous to aclk; analog crystal paths lie outside.
*/
// Decided for this implementation: the AXI4-Lite slave port.
// Function
// RL1 - Oscillator port has bits 3..0 only
// RL2 - Oscillator bits each input/output or crystal
// RL3 - Bits 0,1 high crystal; 2,3 low crystal
// RL4 - Oscillator pull-up only in input mode
// RL5 - Output latch drives pin level; resets zero
// RL6 - Software keeps oscillator direction bits 1:0 clear
// RL7 - Clearing high select with oscillator on resets
// RL8 - Software keeps high crystal select at one
// RL9 - Pin read 1:0 masked by output/select
// RL10 - Pin read 3:2 masked by output/select
// RL11 - Interrupt port has four bidirectional bits
// RL12 - Input bits 3..1 feed interrupts, stop
// RL13 - Bit 0 is reset input after reset
// RL14 - Interrupt pull-up only in input mode
// RL15 - Direction 0 input, 1 output, reset 0
// RL16 - Select bits: 1 crystal; reset 1, 0
// RL17 - Unimplemented bits read zero, ignore writes
`include "ogp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ogp_gpio (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Oscillator-shared port pins
   input wire ogp_pkg::ogp_nib_t osc_pin_i,
   output ogp_pkg::ogp_nib_t osc_pin_o,
   output ogp_pkg::ogp_nib_t osc_pin_oe,
   output ogp_pkg::ogp_nib_t osc_pullup_en,
   // Interrupt-shared port pins
   input wire ogp_pkg::ogp_nib_t irq_pin_i,
   output ogp_pkg::ogp_nib_t irq_pin_o,
   output ogp_pkg::ogp_nib_t irq_pin_oe,
   output ogp_pkg::ogp_nib_t irq_pullup_en,
   // Crystal connections
   output logic hf_crystal_sel,
   output logic lf_crystal_sel,
   output logic hf_crystal_in,
   output logic lf_crystal_in,
   output logic sys_clk_reset_req,
   // Interrupt, stop and reset inputs toward the core
   output logic ext_irq_a,
   output logic ext_irq_b,
   output logic ext_irq_c,
   output logic stop_release,
   output logic ext_reset_n
);
   import ogp_pkg::*;

   ogp_nib_t osc_lat_q, irq_lat_q, osc_dir_q, irq_dir_q;
   ogp_nib_t osc_pu_q, irq_pu_q;
   logic hf_sel_q, lf_sel_q, hf_en_q, p0_port_q;
   ogp_wr_state_t ws_q;
   ogp_rd_state_t rs_q;
   logic aw_have_q, w_have_q;
   logic [31:0] aw_addr_q, w_data_q;
   logic w_lane0_q;

   // Handshake decode
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire wr_go = (ws_q == OGP_WS_COLLECT) & aw_have_q & w_have_q;
   wire b_done = s_axi_bvalid & s_axi_bready;
   wire r_done = s_axi_rvalid & s_axi_rready;

   // Address decode; upper address bits must be zero to hit
   wire [11:0] wr_idx = aw_addr_q[13:2];
   wire wr_in = (aw_addr_q[31:14] == 18'h00000);
   wire wr_osc_lat = wr_in & (wr_idx == `OGP_IDX_OSC_LATCH);
   wire wr_irq_lat = wr_in & (wr_idx == `OGP_IDX_IRQ_LATCH);
   wire wr_osc_pin = wr_in & (wr_idx == `OGP_IDX_OSC_PIN);
   wire wr_osc_dir = wr_in & (wr_idx == `OGP_IDX_OSC_DIR);
   wire wr_irq_dir = wr_in & (wr_idx == `OGP_IDX_IRQ_DIR);
   wire wr_osc_pu = wr_in & (wr_idx == `OGP_IDX_OSC_PU);
   wire wr_irq_pu = wr_in & (wr_idx == `OGP_IDX_IRQ_PU);
   wire wr_fsel = wr_in & (wr_idx == `OGP_IDX_OSC_FSEL);
   wire wr_osc_ctl = wr_in & (wr_idx == `OGP_IDX_OSC_CTRL);
   wire wr_irq_ctl = wr_in & (wr_idx == `OGP_IDX_IRQ_CTRL);
   wire wr_hit = wr_osc_lat | wr_irq_lat | wr_osc_pin | wr_osc_dir |
      wr_irq_dir | wr_osc_pu | wr_irq_pu | wr_fsel | wr_osc_ctl | wr_irq_ctl;
   // Only byte lane 0 carries data; other lanes are ignored
   wire wr_en = wr_go & w_lane0_q;
   wire [3:0] wd = w_data_q[3:0]; // RL17

   // Clearing the high select while the oscillator runs resets the clock
   wire hf_kill = wr_en & wr_fsel & ~w_data_q[`OGP_FSEL_HF] & hf_en_q; // RL7

   // Pin read masking: outputs and crystal pins read as zero
   wire [3:0] xsel = {lf_sel_q, lf_sel_q, hf_sel_q, hf_sel_q};
   ogp_nib_t pin_rd;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_rd
         assign pin_rd[gi] = ~osc_dir_q[gi] & ~xsel[gi] & osc_pin_i[gi]; // RL9 RL10
      end
   endgenerate

   // Read decode; if/else chain so the first hit wins
   wire [11:0] rd_idx = s_axi_araddr[13:2];
   wire rd_in = (s_axi_araddr[31:14] == 18'h00000);
   logic [7:0] rd_val;
   logic rd_hit;
   always_comb begin
      rd_hit = rd_in;
      rd_val = 8'h00;
      if (rd_idx == `OGP_IDX_OSC_LATCH) begin
         rd_val = {4'h0, osc_lat_q}; // RL1
      end else if (rd_idx == `OGP_IDX_IRQ_LATCH) begin
         rd_val = {4'h0, irq_lat_q};
      end else if (rd_idx == `OGP_IDX_OSC_PIN) begin
         rd_val = {4'h0, pin_rd};
      end else if (rd_idx == `OGP_IDX_OSC_DIR) begin
         rd_val = {4'h0, osc_dir_q};
      end else if (rd_idx == `OGP_IDX_IRQ_DIR) begin
         rd_val = {4'h0, irq_dir_q};
      end else if (rd_idx == `OGP_IDX_OSC_PU) begin
         rd_val = {4'h0, osc_pu_q};
      end else if (rd_idx == `OGP_IDX_IRQ_PU) begin
         rd_val = {4'h0, irq_pu_q};
      end else if (rd_idx == `OGP_IDX_OSC_FSEL) begin
         rd_val = {5'h00, lf_sel_q, 1'b0, hf_sel_q}; // RL17
      end else if (rd_idx == `OGP_IDX_OSC_CTRL) begin
         rd_val = {7'h00, hf_en_q};
      end else if (rd_idx == `OGP_IDX_IRQ_CTRL) begin
         rd_val = {7'h00, p0_port_q};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ws_q <= OGP_WS_COLLECT;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 32'h00000000;
         w_data_q <= 32'h00000000;
         w_lane0_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OGP_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_have_q & ~aw_fire & (ws_q == OGP_WS_COLLECT);
         s_axi_wready <= ~w_have_q & ~w_fire & (ws_q == OGP_WS_COLLECT);
         if (aw_fire) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_lane0_q <= s_axi_wstrb[0];
         end
         case (ws_q)
            OGP_WS_COLLECT: begin
               if (wr_go) begin
                  ws_q <= OGP_WS_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? `OGP_RESP_OKAY : `OGP_RESP_SLVERR;
               end
            end
            default: begin
               if (b_done) begin
                  ws_q <= OGP_WS_COLLECT;
                  s_axi_bvalid <= 1'b0;
                  aw_have_q <= 1'b0;
                  w_have_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // Read channel: one read at a time, data one edge after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rs_q <= OGP_RS_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `OGP_RESP_OKAY;
      end else begin
         case (rs_q)
            OGP_RS_IDLE: begin
               s_axi_arready <= ~ar_fire;
               if (ar_fire) begin
                  rs_q <= OGP_RS_DATA;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= {24'h000000, rd_val};
                  s_axi_rresp <= rd_hit ? `OGP_RESP_OKAY : `OGP_RESP_SLVERR;
               end
            end
            default: begin
               if (r_done) begin
                  rs_q <= OGP_RS_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
         endcase
      end
   end

   // Port registers; pin-read index is read-only and ignores writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_lat_q <= `OGP_PORT_RST; // RL5
         irq_lat_q <= `OGP_PORT_RST;
         osc_dir_q <= `OGP_PORT_RST; // RL15
         irq_dir_q <= `OGP_PORT_RST;
         osc_pu_q <= `OGP_PORT_RST;
         irq_pu_q <= `OGP_PORT_RST;
         hf_sel_q <= `OGP_FSEL_HF_RST; // RL16
         lf_sel_q <= `OGP_FSEL_LF_RST;
         hf_en_q <= 1'b0;
         p0_port_q <= 1'b0; // RL13
      end else if (wr_en) begin
         if (wr_osc_lat) osc_lat_q <= wd;
         if (wr_irq_lat) irq_lat_q <= wd;
         if (wr_osc_dir) osc_dir_q <= wd; // RL2
         if (wr_irq_dir) irq_dir_q <= wd; // RL11
         if (wr_osc_pu) osc_pu_q <= wd;
         if (wr_irq_pu) irq_pu_q <= wd;
         if (wr_fsel) begin
            hf_sel_q <= w_data_q[`OGP_FSEL_HF];
            lf_sel_q <= w_data_q[`OGP_FSEL_LF];
         end
         if (wr_osc_ctl) hf_en_q <= w_data_q[`OGP_CTRL_HF_EN];
         if (wr_irq_ctl) p0_port_q <= w_data_q[`OGP_CTRL_P0_PORT];
      end
   end

   // Pin drivers; a crystal pin is never driven even if its direction
   // bit is set, which protects the resonator from a software slip
   wire [3:0] irq_gp = {3'h7, p0_port_q};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_pin_o <= 4'h0;
         osc_pin_oe <= 4'h0;
         osc_pullup_en <= 4'h0;
         irq_pin_o <= 4'h0;
         irq_pin_oe <= 4'h0;
         irq_pullup_en <= 4'h0;
         sys_clk_reset_req <= 1'b0;
      end else begin
         osc_pin_o <= osc_lat_q; // RL5
         osc_pin_oe <= osc_dir_q & ~xsel; // RL3 RL6
         osc_pullup_en <= osc_pu_q & ~osc_dir_q & ~xsel; // RL4
         irq_pin_o <= irq_lat_q;
         irq_pin_oe <= irq_dir_q & irq_gp; // RL13
         irq_pullup_en <= irq_pu_q & ~irq_dir_q; // RL14
         sys_clk_reset_req <= hf_kill; // RL7
      end
   end

   // Secondary inputs: interrupt and stop idle high unless the bit is an input, reset unless p0_port_q is clear; crystal inputs idle low unless selected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hf_crystal_sel <= 1'b1;
         lf_crystal_sel <= 1'b0;
         hf_crystal_in <= 1'b0;
         lf_crystal_in <= 1'b0;
         ext_irq_a <= 1'b1;
         ext_irq_b <= 1'b1;
         ext_irq_c <= 1'b1;
         stop_release <= 1'b1;
         ext_reset_n <= 1'b1;
      end else begin
         hf_crystal_sel <= hf_sel_q; // RL3 RL8
         lf_crystal_sel <= lf_sel_q;
         hf_crystal_in <= hf_sel_q & osc_pin_i[0];
         lf_crystal_in <= lf_sel_q & osc_pin_i[2];
         ext_irq_a <= irq_dir_q[2] | irq_pin_i[2]; // RL12
         ext_irq_b <= irq_dir_q[3] | irq_pin_i[3];
         ext_irq_c <= irq_dir_q[1] | irq_pin_i[1];
         stop_release <= irq_dir_q[1] | irq_pin_i[1];
         ext_reset_n <= p0_port_q | irq_pin_i[0]; // RL13
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_oe_dir;
      ##1 osc_pin_oe == ($past(osc_dir_q) & ~$past(xsel));
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("osc oe wrong"); // RL15

   property p_pu_in;
      ##1 (osc_pullup_en & $past(osc_dir_q)) == 4'h0;
   endproperty
   a_pu_in: assert property (p_pu_in) else $error("osc pull-up on output"); // RL4

   property p_irq_pu;
      ##1 (irq_pullup_en & $past(irq_dir_q)) == 4'h0;
   endproperty
   a_irq_pu: assert property (p_irq_pu) else $error("irq pull-up on output"); // RL14

   property p_hf_kill;
      wr_go && w_lane0_q && wr_fsel && !w_data_q[0] && hf_en_q
         |=> sys_clk_reset_req ##1 !hf_sel_q;
   endproperty
   a_hf_kill: assert property (p_hf_kill) else $error("no clock reset"); // RL7

   property p_irq_out;
      ##1 irq_pin_o == $past(irq_lat_q);
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq latch lost"); // RL5

   property p_rst_pin;
      !p0_port_q |=> !irq_pin_oe[0];
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin driven"); // RL13

   property p_hi_zero;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper bits set"); // RL17

   property p_irq_a;
      !irq_dir_q[2] |=> ext_irq_a == $past(irq_pin_i[2]);
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("irq a not fed"); // RL12

   property p_pin_mask;
      ar_fire && rd_idx == `OGP_IDX_OSC_PIN && hf_sel_q
         |=> s_axi_rdata[1:0] == 2'h0;
   endproperty
   a_pin_mask: assert property (p_pin_mask) else $error("crystal read"); // RL9

   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");

   c_write: cover property (b_done && s_axi_bresp == `OGP_RESP_OKAY);
   c_read: cover property (r_done && rs_q == OGP_RS_DATA);
   c_kill: cover property (sys_clk_reset_req);
   c_unmap: cover property (r_done && s_axi_rresp == `OGP_RESP_SLVERR);
endmodule : ogp_gpio
`default_nettype wire

// *** hw/ogp_regs.svh ***
/*
 Register indices, field positions, reset values and bus codes for the
 oscillator/interrupt GPIO block. Byte address is four times the index.
 Assumes inclusion by the design file and the bench only.
*/
`ifndef OGP_REGS_SVH
`define OGP_REGS_SVH
// Register indices
`define OGP_IDX_OSC_LATCH 12'h000
`define OGP_IDX_IRQ_LATCH 12'h001
`define OGP_IDX_OSC_PIN 12'h00D
`define OGP_IDX_OSC_DIR 12'hF1A
`define OGP_IDX_IRQ_DIR 12'hF1B
`define OGP_IDX_OSC_PU 12'hF27
`define OGP_IDX_IRQ_PU 12'hF28
`define OGP_IDX_OSC_FSEL 12'hF34
`define OGP_IDX_OSC_CTRL 12'hF40
`define OGP_IDX_IRQ_CTRL 12'hF41
// Field positions
`define OGP_FSEL_HF 0
`define OGP_FSEL_LF 2
`define OGP_CTRL_HF_EN 0
`define OGP_CTRL_P0_PORT 0
// Reset values
`define OGP_PORT_RST 4'h0
`define OGP_FSEL_HF_RST 1'b1
`define OGP_FSEL_LF_RST 1'b0
// Bus answers
`define OGP_RESP_OKAY 2'h0
`define OGP_RESP_SLVERR 2'h2
`endif

// *** hw/ogp_pkg.sv ***
/*
 Types of the oscillator/interrupt GPIO block.
 Assumes ogp_regs.svh for the numbers.
*/
package ogp_pkg;
   typedef logic [3:0] ogp_nib_t;
   typedef enum logic [0:0] {
      OGP_WS_COLLECT = 1'b0,
      OGP_WS_RESP = 1'b1
   } ogp_wr_state_t;
   typedef enum logic [0:0] {
      OGP_RS_IDLE = 1'b0,
      OGP_RS_DATA = 1'b1
   } ogp_rd_state_t;
endpackage : ogp_pkg

// *** tb/ogp_pin_model.sv ***
/*
 Pin model: one 4-bit port with its outside world.
 Assumes the bench sets the outside drive and its enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ogp_pin_model (
   // Clock
   input wire logic aclk,
   // Device side
   input wire logic [3:0] oe,
   input wire logic [3:0] o,
   input wire logic [3:0] pu,
   // Outside drive
   input wire logic [3:0] ext_v,
   input wire logic [3:0] ext_en,
   // Resolved level
   output logic [3:0] pin
);
   logic [3:0] flt_q;
   // A floating pin wanders so that no stale level passes for a real one;
   // plain always because the start value comes from an initial block
   always @(posedge aclk) begin
      flt_q <= ~flt_q;
   end
   initial flt_q = 4'h5;
   // Device drive wins, then outside drive, then pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = oe[i] ? o[i] : ext_en[i] ? ext_v[i] : pu[i] ? 1'b1 : flt_q[i];
      end
   end
endmodule : ogp_pin_model
`default_nettype wire

// *** tb/osc_and_irq_gpio_ports_tb.sv ***
/*
 Bench for the GPIO block: AXI4-Lite tasks and register/pin tests.
 Assumes the pin model stands on both ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ogp_regs.svh"
module osc_and_irq_gpio_ports_tb;
   import ogp_pkg::*;
   logic aclk, aresetn;
   logic [31:0] awaddr, wdata, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   ogp_nib_t osc_i, osc_o, osc_oe, osc_pu, irq_i, irq_o, irq_oe, irq_pu;
   logic [3:0] osc_v, osc_en, irq_v, irq_en;
   logic hf_sel, lf_sel, hf_in, lf_in, clk_rst;
   logic irq_a, irq_b, irq_c, stop_rel, rst_n;
   int failures, num_checks, pulses;
   logic [1:0] resp;
   logic [31:0] rd;

   ogp_gpio u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_pin_i(osc_i), .osc_pin_o(osc_o), .osc_pin_oe(osc_oe),
      .osc_pullup_en(osc_pu), .irq_pin_i(irq_i), .irq_pin_o(irq_o),
      .irq_pin_oe(irq_oe), .irq_pullup_en(irq_pu),
      .hf_crystal_sel(hf_sel), .lf_crystal_sel(lf_sel),
      .hf_crystal_in(hf_in), .lf_crystal_in(lf_in),
      .sys_clk_reset_req(clk_rst), .ext_irq_a(irq_a), .ext_irq_b(irq_b),
      .ext_irq_c(irq_c), .stop_release(stop_rel), .ext_reset_n(rst_n));
   ogp_pin_model u_osc (.aclk(aclk), .oe(osc_oe), .o(osc_o), .pu(osc_pu),
      .ext_v(osc_v), .ext_en(osc_en), .pin(osc_i));
   ogp_pin_model u_irq (.aclk(aclk), .oe(irq_oe), .o(irq_o), .pu(irq_pu),
      .ext_v(irq_v), .ext_en(irq_en), .pin(irq_i));

   // Clock generation
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Count clock reset pulses as they stand
   always @(posedge aclk) begin
      if (clk_rst === 1'b1) pulses++;
   end

   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= {18'h0, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [11:0] idx);
      @(posedge aclk);
      araddr <= {18'h0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rdr

   task automatic rchk(input logic [11:0] idx, input logic [7:0] e);
      rdr(idx);
      chk("rdata", {24'h0, e}, rd);
      chk("rresp", 32'h0, {30'h0, resp});
   endtask : rchk

   // Pins follow registers one edge later
   task automatic settle;
      repeat (2) @(posedge aclk);
      #1;
   endtask : settle

   // Watchdog
   initial begin
      repeat (5000) @(posedge aclk);
      failures++;
      complete_run();
   end

   // Main sequence
   initial begin
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      osc_v = 4'hF;
      osc_en = 4'hF;
      irq_v = 4'hA;
      irq_en = 4'hF;
      aresetn = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`OGP_IDX_OSC_LATCH, 8'h00);
      rchk(`OGP_IDX_IRQ_LATCH, 8'h00);
      rchk(`OGP_IDX_OSC_DIR, 8'h00);
      rchk(`OGP_IDX_IRQ_DIR, 8'h00);
      rchk(`OGP_IDX_OSC_PU, 8'h00);
      rchk(`OGP_IDX_OSC_FSEL, 8'h01);
      rchk(`OGP_IDX_OSC_PIN, 8'h0C);
      chk("hf_in", 32'h1, {31'h0, hf_in});
      rdr(12'h123);
      chk("bad_rresp", 32'h2, {30'h0, resp});
      wr(12'h123, 8'hFF);
      chk("bad_bresp", 32'h2, {30'h0, resp});
      // Upper nibble is not there
      wr(`OGP_IDX_OSC_LATCH, 8'hFF);
      rchk(`OGP_IDX_OSC_LATCH, 8'h0F);
      // Lane 0 strobe low: the write must leave the latch alone
      wstrb <= 4'hE;
      wr(`OGP_IDX_OSC_LATCH, 8'h00);
      wstrb <= 4'hF;
      rchk(`OGP_IDX_OSC_LATCH, 8'h0F);
      wr(`OGP_IDX_OSC_DIR, 8'hFC);
      rchk(`OGP_IDX_OSC_DIR, 8'h0C);
      settle();
      chk("osc_oe", 32'hC, {28'h0, osc_oe});
      chk("osc_o", 32'hF, {28'h0, osc_o});
      rchk(`OGP_IDX_OSC_PIN, 8'h00);
      // Oscillator off: dropping the select must not reset
      wr(`OGP_IDX_OSC_FSEL, 8'h00);
      wr(`OGP_IDX_OSC_DIR, 8'h00);
      osc_v <= 4'h9;
      rchk(`OGP_IDX_OSC_PIN, 8'h09);
      wr(`OGP_IDX_OSC_FSEL, 8'h04);
      rchk(`OGP_IDX_OSC_PIN, 8'h01);
      settle();
      chk("sel", 32'h1, {30'h0, hf_sel, lf_sel});
      chk("lf_in", 32'h0, {31'h0, lf_in});
      // Pull-ups hold released inputs high, not outputs
      wr(`OGP_IDX_OSC_FSEL, 8'h00);
      wr(`OGP_IDX_OSC_PU, 8'h0F);
      wr(`OGP_IDX_OSC_DIR, 8'h08);
      osc_en <= 4'h0;
      settle();
      chk("osc_pu", 32'h7, {28'h0, osc_pu});
      rchk(`OGP_IDX_OSC_PIN, 8'h07);
      chk("pulses0", 32'h0, pulses);
      // Oscillator on: only clearing the select resets
      wr(`OGP_IDX_OSC_CTRL, 8'h01);
      wr(`OGP_IDX_OSC_FSEL, 8'h01);
      settle();
      chk("pulses1", 32'h0, pulses);
      wr(`OGP_IDX_OSC_FSEL, 8'h00);
      settle();
      chk("pulses2", 32'h1, pulses);
      wr(`OGP_IDX_OSC_FSEL, 8'h01);
      // Interrupt port inputs
      chk("irq_in", 32'h0E,
          {27'h0, irq_a, irq_b, irq_c, stop_rel, rst_n});
      wr(`OGP_IDX_IRQ_PU, 8'h0F);
      settle();
      chk("irq_pu", 32'hF, {28'h0, irq_pu});
      wr(`OGP_IDX_IRQ_LATCH, 8'h05);
      wr(`OGP_IDX_IRQ_DIR, 8'h0F);
      settle();
      chk("irq_oe", 32'hE, {28'h0, irq_oe});
      wr(`OGP_IDX_IRQ_CTRL, 8'h01);
      settle();
      chk("irq_oe2", 32'hF, {28'h0, irq_oe});
      chk("irq_o", 32'h5, {28'h0, irq_o});
      chk("irq_pu2", 32'h0, {28'h0, irq_pu});
      chk("irq_out", 32'h1F,
          {27'h0, irq_a, irq_b, irq_c, stop_rel, rst_n});
      complete_run();
   end
endmodule : osc_and_irq_gpio_ports_tb
`default_nettype wire
